// ---- verilog/pim_defs.svh ----
// Function
// - each image direction is a six-byte parameter block plus 6/8/18/30/42 data bytes
// - selected image size is held in the dedicated image size register
// - a new size takes effect only at the coupler restart; old layout stays
// - small output image: control bytes, four out parameters, then data bytes 0 to 5
// - small input image: status bytes, in parameters, four port statuses, data 0 and 1
// - compressed packing comes from the master control register and covers all ports
// - compressed packing also applies to the larger images, data continuing from byte 2
// - compressed process mode: output bytes 4 and 5 carry data 0 and 1
// - compressed: input bytes 0,1 packed port status and 4,5 data in process mode
// - with error reaction enabled, a faulty port's input data reads as zero
// - vendor and device identifiers are optionally compared at port start-up
// - ports have several modes, default communication, and a master cycle time
// - packed status: lower port in low nibble, higher port in high nibble
// - after reset the image size register selects the 24-byte image
`ifndef PIM_DEFS_SVH
`define PIM_DEFS_SVH

// ---------------------------------------------------------------
// image layout
// ---------------------------------------------------------------
`define PIM_PARAM_BYTES 6
`define PIM_MAX_BYTES 48
`define PIM_DATA_BYTES 44
`define PIM_CHUNK_BYTES 12
`define PIM_CHUNKS 4
`define PIM_PSTAT_BYTES 4
`define PIM_CB_REGCOM_BIT 7

// ---------------------------------------------------------------
// size codes and reset values
// ---------------------------------------------------------------
`define PIM_SIZE_12 3'h0
`define PIM_SIZE_14 3'h1
`define PIM_SIZE_24 3'h2
`define PIM_SIZE_36 3'h3
`define PIM_SIZE_48 3'h4
`define PIM_SIZE_RST 3'h2
`define PIM_CYCLE_RST 8'h17

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PIM_CLK_NS 20
`define PIM_CYCLE_UNIT_NS 100000

`endif

// ---- verilog/pim_pkg.sv ----
package pim_pkg;

  typedef enum logic [1:0] {
    PIM_MODE_COMM = 2'h0,
    PIM_MODE_DIG_IN = 2'h1,
    PIM_MODE_DIG_OUT = 2'h2,
    PIM_MODE_OFF = 2'h3
  } pim_mode_t;

  // per-port settings written by the configuration path
  typedef struct packed {
    logic check_vendor;
    logic check_device;
    logic err_react;
    pim_mode_t mode;
    logic [7:0] cycle_time;
    logic [15:0] vendor_id;
    logic [23:0] device_id;
  } pim_port_cfg_t;

  // identity reported by an attached device at start-up
  typedef struct packed {
    logic [15:0] vendor_id;
    logic [23:0] device_id;
  } pim_dev_id_t;

endpackage

// ---- verilog/pim_mapper.sv ----
`timescale 1ns/1ps
`include "pim_defs.svh"

module pim_mapper
  import pim_pkg::*;
#(
  parameter int CYCLE_UNIT_CLKS = `PIM_CYCLE_UNIT_NS / `PIM_CLK_NS,
  parameter logic [7:0] CYCLE_RST = `PIM_CYCLE_RST
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // image size and master control
  input wire logic size_wr_in,
  input wire logic [2:0] size_code_in,
  input wire logic restart_in,
  input wire logic mctl_wr_in,
  input wire logic mctl_compress_in,
  output logic [2:0] image_size_reg_out,
  output logic [2:0] active_size_out,
  output logic compress_out,
  // exchange with the coupler
  input wire logic wr_valid_in,
  input wire logic [1:0] wr_chunk_in,
  input wire logic [95:0] wr_data_in,
  input wire logic rd_req_in,
  input wire logic [1:0] rd_chunk_in,
  output logic rd_valid_out,
  output logic [95:0] rd_data_out,
  // output fields towards the ports
  input wire logic [5:0] out_len_in,
  output logic [7:0] control_byte_zero_out,
  output logic [7:0] control_byte_one_out,
  output logic [3:0][7:0] out_param_byte_out,
  output logic [43:0][7:0] port_out_byte_out,
  output logic proc_mode_out,
  // input fields from the ports
  input wire logic [7:0] status_byte_zero_in,
  input wire logic [7:0] status_byte_one_in,
  input wire logic [3:0][7:0] in_param_byte_in,
  input wire logic [3:0][3:0] port_status_in,
  input wire logic [43:0][7:0] port_in_byte_in,
  input wire logic [3:0][5:0] in_len_in,
  input wire logic [3:0] port_error_in,
  // per-port configuration and start-up
  input wire logic [3:0] cfg_wr_in,
  input wire pim_port_cfg_t cfg_in,
  input wire logic [3:0] startup_in,
  input wire pim_dev_id_t [3:0] dev_id_in,
  output logic [3:0] id_ok_out,
  output logic [3:0] id_fail_out,
  output logic [3:0][1:0] port_mode_out,
  output logic [3:0] cycle_tick_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] img_total(input logic [2:0] code);
    unique case (code)
      `PIM_SIZE_12: img_total = 6'd12;
      `PIM_SIZE_14: img_total = 6'd14;
      `PIM_SIZE_24: img_total = 6'd24;
      `PIM_SIZE_36: img_total = 6'd36;
      default: img_total = 6'd48;
    endcase
  endfunction

  function automatic logic size_legal(input logic [2:0] code);
    size_legal = (code <= `PIM_SIZE_48);
  endfunction

  // ---------------------------------------------------------------
  // image size and master control
  // ---------------------------------------------------------------
  logic [2:0] size_reg_r;
  logic [2:0] active_size_r;
  logic compress_r;
  logic [5:0] total;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      size_reg_r <= `PIM_SIZE_RST;
    end else if (size_wr_in && size_legal(size_code_in)) begin
      size_reg_r <= size_code_in;
    end
  end

  // layout changes only when the coupler restarts, so a half-written image never
  // gets reinterpreted mid-exchange
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      active_size_r <= `PIM_SIZE_RST;
    end else if (restart_in) begin
      active_size_r <= size_reg_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      compress_r <= 1'b0;
    end else if (mctl_wr_in) begin
      compress_r <= mctl_compress_in;
    end
  end

  assign total = img_total(active_size_r);
  assign image_size_reg_out = size_reg_r;
  assign active_size_out = active_size_r;
  assign compress_out = compress_r;

  // ---------------------------------------------------------------
  // output image store
  // ---------------------------------------------------------------
  logic [7:0] out_img_r [`PIM_MAX_BYTES];
  logic proc_mode;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int i = 0; i < `PIM_MAX_BYTES; i++) begin
        out_img_r[i] <= 8'h00;
      end
    end else if (wr_valid_in) begin
      // one chunk per local bus cycle; bytes past the image end are dropped
      for (int i = 0; i < `PIM_CHUNK_BYTES; i++) begin
        if (6'(int'(wr_chunk_in) * `PIM_CHUNK_BYTES + i) < total) begin
          out_img_r[int'(wr_chunk_in) * `PIM_CHUNK_BYTES + i] <= wr_data_in[i*8 +: 8];
        end
      end
    end
  end

  // register communication is flagged in control byte zero
  assign proc_mode = ~out_img_r[0][`PIM_CB_REGCOM_BIT];
  assign proc_mode_out = proc_mode;

  // ---------------------------------------------------------------
  // output field decode
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      control_byte_zero_out <= 8'h00;
      control_byte_one_out <= 8'h00;
      out_param_byte_out <= '0;
    end else begin
      control_byte_zero_out <= out_img_r[0];
      control_byte_one_out <= out_img_r[1];
      out_param_byte_out[0] <= out_img_r[2];
      out_param_byte_out[1] <= out_img_r[3];
      if (compress_r && proc_mode) begin
        out_param_byte_out[2] <= 8'h00;
        out_param_byte_out[3] <= 8'h00;
      end else begin
        out_param_byte_out[2] <= out_img_r[4];
        out_param_byte_out[3] <= out_img_r[5];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      port_out_byte_out <= '0;
    end else begin
      for (int k = 0; k < `PIM_DATA_BYTES; k++) begin
        port_out_byte_out[k] <= 8'h00;
        if (6'(k) < out_len_in) begin
          if (compress_r) begin
            if (k >= 2 && 6'(k + 4) < total) begin
              port_out_byte_out[k] <= out_img_r[k + 4];
            end else if (k < 2 && proc_mode) begin
              port_out_byte_out[k] <= out_img_r[k + 4];
            end
          end else if (6'(k + `PIM_PARAM_BYTES) < total) begin
            port_out_byte_out[k] <= out_img_r[k + `PIM_PARAM_BYTES];
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // port configuration
  // ---------------------------------------------------------------
  pim_port_cfg_t cfg_r [4];

  always_ff @(posedge clock_in) begin
    for (int p = 0; p < 4; p++) begin
      if (rst_in) begin
        cfg_r[p] <= '{check_vendor: 1'b0, check_device: 1'b0, err_react: 1'b0,
                      mode: PIM_MODE_COMM, cycle_time: CYCLE_RST,
                      vendor_id: 16'h0000, device_id: 24'h000000};
      end else if (cfg_wr_in[p]) begin
        cfg_r[p] <= cfg_in;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      port_mode_out[p] = cfg_r[p].mode;
    end
  end

  // ---------------------------------------------------------------
  // input image assembly
  // ---------------------------------------------------------------
  logic [7:0] in_img [`PIM_MAX_BYTES];
  logic [7:0] in_data [`PIM_DATA_BYTES];

  // input bytes are packed port after port; a port in error with error reaction
  // enabled contributes zeros so the controller never sees stale values
  always_comb begin
    logic [5:0] start;
    logic masked;
    start = 6'd0;
    masked = 1'b0;
    for (int k = 0; k < `PIM_DATA_BYTES; k++) begin
      in_data[k] = 8'h00;
    end
    for (int p = 0; p < 4; p++) begin
      masked = cfg_r[p].err_react && port_error_in[p];
      for (int k = 0; k < `PIM_DATA_BYTES; k++) begin
        if (6'(k) >= start && 6'(k) < 6'(start + in_len_in[p]) && !masked) begin
          in_data[k] = port_in_byte_in[k];
        end
      end
      start = 6'(start + in_len_in[p]);
    end
  end

  always_comb begin
    for (int i = 0; i < `PIM_MAX_BYTES; i++) begin
      in_img[i] = 8'h00;
    end
    if (compress_r && proc_mode) begin
      in_img[0] = {port_status_in[1], port_status_in[0]};
      in_img[1] = {port_status_in[3], port_status_in[2]};
      in_img[4] = in_data[0];
      in_img[5] = in_data[1];
    end else begin
      in_img[0] = status_byte_zero_in;
      in_img[1] = status_byte_one_in;
      in_img[4] = in_param_byte_in[2];
      in_img[5] = in_param_byte_in[3];
    end
    in_img[2] = in_param_byte_in[0];
    in_img[3] = in_param_byte_in[1];
    if (compress_r) begin
      for (int i = `PIM_PARAM_BYTES; i < `PIM_MAX_BYTES; i++) begin
        if (6'(i) < total) begin
          in_img[i] = in_data[i - 4];
        end
      end
    end else begin
      for (int p = 0; p < `PIM_PSTAT_BYTES; p++) begin
        in_img[`PIM_PARAM_BYTES + p] = {4'h0, port_status_in[p]};
      end
      for (int i = 10; i < `PIM_MAX_BYTES; i++) begin
        if (6'(i) < total) begin
          in_img[i] = in_data[i - 10];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // coupler read of the input image
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else begin
      rd_valid_out <= rd_req_in;
      if (rd_req_in) begin
        for (int i = 0; i < `PIM_CHUNK_BYTES; i++) begin
          rd_data_out[i*8 +: 8] <= in_img[int'(rd_chunk_in) * `PIM_CHUNK_BYTES + i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // start-up identity checks
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    for (int p = 0; p < 4; p++) begin
      if (rst_in) begin
        id_ok_out[p] <= 1'b0;
        id_fail_out[p] <= 1'b0;
      end else if (startup_in[p]) begin
        // a disabled check always passes
        id_ok_out[p] <= (!cfg_r[p].check_vendor || dev_id_in[p].vendor_id == cfg_r[p].vendor_id)
          && (!cfg_r[p].check_device || dev_id_in[p].device_id == cfg_r[p].device_id);
        id_fail_out[p] <= !((!cfg_r[p].check_vendor ||
          dev_id_in[p].vendor_id == cfg_r[p].vendor_id) && (!cfg_r[p].check_device ||
          dev_id_in[p].device_id == cfg_r[p].device_id));
      end
    end
  end

  // ---------------------------------------------------------------
  // master cycle timing
  // ---------------------------------------------------------------
  logic [31:0] unit_cnt_r;
  logic unit_tick;
  logic [7:0] cyc_cnt_r [4];

  always_ff @(posedge clock_in) begin
    if (rst_in || unit_tick) begin
      unit_cnt_r <= 32'h0;
    end else begin
      unit_cnt_r <= unit_cnt_r + 32'h1;
    end
  end

  assign unit_tick = (unit_cnt_r == 32'(CYCLE_UNIT_CLKS - 1));

  // cycle time counts 100 us units; zero is treated as one unit
  always_ff @(posedge clock_in) begin
    for (int p = 0; p < 4; p++) begin
      if (rst_in) begin
        cyc_cnt_r[p] <= 8'h00;
        cycle_tick_out[p] <= 1'b0;
      end else begin
        cycle_tick_out[p] <= 1'b0;
        if (unit_tick) begin
          if (cyc_cnt_r[p] + 8'h01 >= cfg_r[p].cycle_time) begin
            cyc_cnt_r[p] <= 8'h00;
            cycle_tick_out[p] <= (cfg_r[p].mode == PIM_MODE_COMM);
          end else begin
            cyc_cnt_r[p] <= cyc_cnt_r[p] + 8'h01;
          end
        end
      end
    end
  end

endmodule // pim_mapper

// ---- verification/pim_mapper_checker.sv ----
`timescale 1ns/1ps
module pim_mapper_checker (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // watched ports
  input wire logic size_wr_in,
  input wire logic [2:0] size_code_in,
  input wire logic restart_in,
  input wire logic mctl_wr_in,
  input wire logic mctl_compress_in,
  input wire logic [2:0] image_size_reg_out,
  input wire logic [2:0] active_size_out,
  input wire logic compress_out,
  input wire logic rd_req_in,
  input wire logic rd_valid_out,
  input wire logic [3:0] startup_in,
  input wire logic [3:0] id_ok_out,
  input wire logic [3:0] id_fail_out,
  input wire logic [3:0][1:0] port_mode_out,
  input wire logic [3:0] cycle_tick_out
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_reset_layout: assert property (disable iff (1'b0)
    rst_in |=> image_size_reg_out == 3'h2 && active_size_out == 3'h2 && port_mode_out == 8'h0)
    else $error("reset layout wrong");
  a_size_store: assert property (
    size_wr_in && size_code_in <= 3'h4 |=> image_size_reg_out == $past(size_code_in))
    else $error("size code not stored");
  a_size_refuse: assert property (
    (!size_wr_in || size_code_in > 3'h4) |=> $stable(image_size_reg_out))
    else $error("size register changed without valid write");
  a_layout_wait: assert property (!restart_in |=> $stable(active_size_out))
    else $error("layout changed without restart");
  a_restart_apply: assert property (
    restart_in |=> active_size_out == $past(image_size_reg_out))
    else $error("restart did not apply size");
  a_compress_set: assert property (
    mctl_wr_in |=> compress_out == $past(mctl_compress_in))
    else $error("compress setting not taken");
  a_compress_hold: assert property (!mctl_wr_in |=> $stable(compress_out))
    else $error("compress changed without write");
  a_read_answer: assert property (rd_req_in |=> rd_valid_out)
    else $error("read not answered");
  a_read_cause: assert property (rd_valid_out |-> $past(rd_req_in))
    else $error("read answer without request");
  a_startup_verdict: assert property (
    startup_in != 4'h0 |=> ((id_ok_out ^ id_fail_out) & $past(startup_in)) == $past(startup_in))
    else $error("start-up verdict not exclusive");
  a_verdict_hold: assert property (
    startup_in == 4'h0 |=> $stable(id_ok_out) && $stable(id_fail_out))
    else $error("start-up verdict changed without start-up");
  c_restart: cover property (restart_in);
  c_comp_read: cover property (rd_valid_out && compress_out);
  c_tick: cover property (cycle_tick_out[0]);
endmodule // pim_mapper_checker

bind pim_mapper pim_mapper_checker chk_i (.*);

// ---- verification/pim_coupler.sv ----
`timescale 1ns/1ps
module pim_coupler (
  // clock
  input wire logic clock_in,
  // local bus towards the mapper
  output logic restart_in,
  output logic wr_valid_in,
  output logic [1:0] wr_chunk_in,
  output logic [95:0] wr_data_in,
  output logic rd_req_in,
  output logic [1:0] rd_chunk_in,
  input wire logic rd_valid_out,
  input wire logic [95:0] rd_data_out
);
  initial begin
    restart_in = 1'b0;
    wr_valid_in = 1'b0;
    wr_chunk_in = 2'h0;
    wr_data_in = '0;
    rd_req_in = 1'b0;
    rd_chunk_in = 2'h0;
  end
  // a new size needs a restart to show
  task automatic restart();
    @(posedge clock_in);
    restart_in <= 1'b1;
    @(posedge clock_in);
    restart_in <= 1'b0;
  endtask
  // whole image, never more than one chunk per cycle
  task automatic send(input logic [47:0][7:0] im);
    for (int c = 0; c < 4; c++) begin
      @(posedge clock_in);
      wr_valid_in <= 1'b1;
      wr_chunk_in <= c[1:0];
      wr_data_in <= im[c*12+:12];
    end
    @(posedge clock_in);
    wr_valid_in <= 1'b0;
    wr_data_in <= ~wr_data_in;
  endtask
  task automatic get(input logic [1:0] c, output logic [95:0] d, output logic ok);
    @(posedge clock_in);
    rd_req_in <= 1'b1;
    rd_chunk_in <= c;
    @(posedge clock_in);
    rd_req_in <= 1'b0;
    rd_chunk_in <= ~c;
    #1;
    ok = rd_valid_out;
    d = rd_data_out;
  endtask
endmodule // pim_coupler

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import pim_pkg::*;
  logic clock_in = 0, rst_in = 1, size_wr_in = 0, mctl_wr_in = 0, mctl_compress_in = 0;
  logic restart_in, wr_valid_in, rd_req_in, rd_valid_out, proc_mode_out, compress_out;
  logic [2:0] size_code_in = 0, image_size_reg_out, active_size_out;
  logic [1:0] wr_chunk_in, rd_chunk_in;
  logic [95:0] wr_data_in, rd_data_out;
  logic [5:0] out_len_in = 6'h28;
  logic [7:0] control_byte_zero_out, control_byte_one_out;
  logic [7:0] status_byte_zero_in = 0, status_byte_one_in = 0;
  logic [3:0][7:0] out_param_byte_out, in_param_byte_in = 0;
  logic [43:0][7:0] port_out_byte_out, port_in_byte_in = 0;
  logic [3:0][3:0] port_status_in = 0;
  logic [3:0][5:0] in_len_in = {4{6'hb}};
  logic [3:0] port_error_in = 0, cfg_wr_in = 0, startup_in = 0;
  logic [3:0] id_ok_out, id_fail_out, cycle_tick_out;
  logic [3:0][1:0] port_mode_out;
  pim_port_cfg_t cfg_in = '0;
  pim_dev_id_t [3:0] dev_id_in = '0;
  logic [47:0][7:0] img;
  int seed = 74, err_count = 0, n_checks = 0, sz = 2, tt[5] = '{12, 14, 24, 36, 48};
  logic cmp = 0;

  pim_mapper #(.CYCLE_UNIT_CLKS(4)) DUT (.*);
  pim_coupler cpl (.*);

  initial forever #10 clock_in = ~clock_in;
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end
  // ----------------------------------------
  // checking and expectations
  // ----------------------------------------
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // input data is packed port after port; port 2 runs with error reaction off
  function automatic logic [7:0] din(int k);
    int st;
    st = 0;
    for (int p = 0; p < 4; p++) begin
      if (k >= st && k < st + in_len_in[p])
        return (port_error_in[p] && p != 2) ? 8'h0 : port_in_byte_in[k];
      st += in_len_in[p];
    end
    return 8'h0;
  endfunction
  function automatic logic [7:0] ein(int b);
    logic pm;
    pm = cmp && !img[0][7];
    if (b >= tt[sz]) return 8'h0;
    if (pm && b < 2) return {port_status_in[2*b+1], port_status_in[2*b]};
    if (b < 2) return b ? status_byte_one_in : status_byte_zero_in;
    if (b < 6 && !(pm && b > 3)) return in_param_byte_in[b-2];
    if (cmp) return din(b - 4);
    if (b < 10) return {4'h0, port_status_in[b-6]};
    return din(b - 10);
  endfunction
  function automatic logic [7:0] eod(int k);
    int b;
    b = cmp ? k + 4 : k + 6;
    if (cmp && k < 2 && img[0][7]) b = 99;
    if (k >= out_len_in || b >= tt[sz]) return 8'h0;
    return img[b];
  endfunction
  task automatic run(input logic [2:0] s, input logic c, input logic rm);
    logic [95:0] d, r;
    logic ok;
    @(posedge clock_in);
    size_wr_in <= 1'b1;
    size_code_in <= s;
    mctl_wr_in <= 1'b1;
    mctl_compress_in <= c;
    for (int i = 0; i < 44; i++) port_in_byte_in[i] <= 8'($random(seed));
    r = {$random(seed), $random(seed), $random(seed)};
    {status_byte_zero_in, status_byte_one_in, in_param_byte_in, port_status_in} <= r[63:0];
    port_error_in <= r[67:64];
    // port data width for which this image is the smallest that fits
    out_len_in <= 6'(tt[s] - 6 - ($random(seed) & 1));
    for (int p = 0; p < 4; p++) in_len_in[p] <= 6'(($random(seed) & 7) + 4);
    @(posedge clock_in);
    size_wr_in <= 1'b0;
    mctl_wr_in <= 1'b0;
    #1;
    chk(image_size_reg_out, s);
    chk(active_size_out, sz);
    chk(compress_out, c);
    cpl.restart();
    sz = s;
    cmp = c;
    for (int i = 0; i < 48; i++) img[i] = 8'($random(seed));
    img[0][7] = rm;
    cpl.send(img);
    @(posedge clock_in);
    #1;
    chk(active_size_out, s);
    chk({control_byte_one_out, control_byte_zero_out}, {img[1], img[0]});
    chk(proc_mode_out, !rm);
    for (int p = 0; p < 4; p++) chk(out_param_byte_out[p], (c && !rm && p > 1) ? 8'h0 : img[p+2]);
    for (int k = 0; k < 44; k++) chk(port_out_byte_out[k], eod(k));
    for (int q = 0; q < 4; q++) begin
      cpl.get(q[1:0], d, ok);
      chk(ok, 1'b1);
      for (int i = 0; i < 12; i++) r[8*i+:8] = ein(12 * q + i);
      chk(d, r);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] t, u;
    t = 8'h0;
    u = 8'h0;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    #1;
    chk({image_size_reg_out, active_size_out}, 6'h12);
    chk(port_mode_out, 8'h0);
    @(posedge clock_in);
    // vendor code below is arbitrary
    cfg_in <= {3'h7, PIM_MODE_COMM, 8'h1, 16'h5a5a, 24'h123456};
    cfg_wr_in <= 4'hf;
    dev_id_in <= {40'h5a5a000000, 40'h005a123456, 40'h005a123456, 40'h5a5a123456};
    @(posedge clock_in);
    cfg_in <= {3'h0, PIM_MODE_OFF, 8'h1, 16'h5a5a, 24'h123456};
    cfg_wr_in <= 4'h4;
    @(posedge clock_in);
    cfg_wr_in <= 4'h0;
    startup_in <= 4'hf;
    @(posedge clock_in);
    startup_in <= 4'h0;
    #1;
    chk({id_fail_out, id_ok_out}, 8'ha5);
    chk(port_mode_out, 8'h30);
    repeat (20) begin
      @(posedge clock_in);
      #1;
      t += cycle_tick_out[0];
      u += cycle_tick_out[2];
    end
    chk(t, 8'h5);
    chk(u, 8'h0);
    @(posedge clock_in);
    size_wr_in <= 1'b1;
    size_code_in <= 3'h5;
    @(posedge clock_in);
    size_wr_in <= 1'b0;
    #1;
    chk(image_size_reg_out, 3'h2);
    for (int s = 0; s < 5; s++)
      for (int m = 0; m < 4; m++) run(s[2:0], m[0], m[1]);
    stop_test();
  end
endmodule // tb
